// [rtl/mwg_regs.v]
// Warning status, pin control/routing and password entry registers
//
// Function
// [RQ1] Bits 7/6 show monitor three last above high / below low.
// [RQ2] Bits 5/4 show monitor four high/low; bits 3..0 read zero.
// [RQ3] Reserved locations read zero and ignore writes.
// [RQ4] Writing 1 to output bit 7 clears the quick-trip latch.
// [RQ5] Output bit 6 forces quick-trip alarm and stops regulator pulses.
// [RQ6] Output bits 3..0 drive pins low at 0, release at 1.
// [RQ7] Output register loads powerup defaults, then is freely read/written.
// [RQ8] Input register bits 3..0 reflect the four pin levels.
// [RQ9] Route select bit 6 puts quick-trip on pin two.
// [RQ10] Bit 7 inverts routed quick-trip; inert unless bit 6 set.
// [RQ11] Route select bit 4 puts signal-absent input on pin zero.
// [RQ12] Bit 5 inverts routed signal-absent; inert unless bit 4 set.
// [RQ13] Routing and inversion bits come from defaults; host writes ignored.
// [RQ14] Password entry is 32-bit, write-any, resets to ones, reads zero.
// [RQ15] Two passwords; level two includes all of level one.
// [RQ16] Reference passwords come from protected nonvolatile storage.
// [RQ17] Access level granted while entry matches a stored password.
// [RQ18] Writes to read-only places ignored; reserved bits read zero.
// [RQ19] Password entry most significant byte sits at lowest address.
`timescale 1ns/1ps
`include "mwg_defs.vh"
module mwg_regs #(
  parameter PW_WIDTH = 32
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire monitor_three_high_warning_i,
  input wire monitor_three_low_warning_i,
  input wire monitor_four_high_warning_i,
  input wire monitor_four_low_warning_i,
  input wire monitor_three_trip_i,
  input wire [7:0] powerup_pin_defaults_i,
  input wire defaults_valid_i,
  input wire [PW_WIDTH-1:0] level_one_password_i,
  input wire [PW_WIDTH-1:0] level_two_password_i,
  input wire signal_absent_input_i,
  input wire [3:0] gpio_pin_i,
  output wire [3:0] gpio_pin_o,
  output wire [3:0] gpio_pin_oe_o,
  output reg monitor_three_quick_trip_o,
  output reg regulator_pulse_enable_o,
  output reg level_one_access_o,
  output reg level_two_access_o
);
  reg [7:0] warn_reg;
  reg [7:0] dout_reg;
  reg [3:0] route_reg;
  reg [PW_WIDTH-1:0] pwe_reg;
  reg qt_latch_reg;
  reg loaded_reg;
  reg [7:0] rdata_next;
  reg [3:0] drive_next;
  wire [3:0] pin_level;
  wire m1;
  wire m2;
  wire qt_internal;
  wire [1:0] pwe_idx;

  // Latch holds trip until cleared; force overrides the comparison
  assign qt_internal = dout_reg[`MWG_BIT_QT_FORCE] | qt_latch_reg; // [RQ5]
  assign pwe_idx = addr_i[1:0] - 2'b11;

  // Warning status mirrors the last measurement only
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      warn_reg <= `MWG_ZERO_BYTE;
    end else begin
      warn_reg <= {monitor_three_high_warning_i, // [RQ1]
                   monitor_three_low_warning_i, // [RQ1]
                   monitor_four_high_warning_i, // [RQ2]
                   monitor_four_low_warning_i, // [RQ2]
                   4'h0}; // [RQ2]
    end
  end

  // Defaults are recalled once after reset, once the store reports valid
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_reg <= `MWG_ZERO_BYTE;
      route_reg <= 4'h0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      if (defaults_valid_i) begin
        dout_reg <= powerup_pin_defaults_i & 8'hCF; // [RQ7]
        route_reg <= powerup_pin_defaults_i[7:4]; // [RQ13]
        loaded_reg <= 1'b1;
      end
    end else if (wr_en_i && addr_i == `MWG_ADDR_DOUT_CTL) begin
      dout_reg <= wdata_i & 8'hCF; // [RQ7]
    end else begin
      // Clear bit is a command, not stored state
      dout_reg[`MWG_BIT_QT_CLR] <= 1'b0;
    end
  end

  // Trip set wins over a clear in the same cycle
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qt_latch_reg <= 1'b0;
    end else if (monitor_three_trip_i) begin
      qt_latch_reg <= 1'b1;
    end else if (wr_en_i && addr_i == `MWG_ADDR_DOUT_CTL &&
                 wdata_i[`MWG_BIT_QT_CLR] && loaded_reg) begin
      qt_latch_reg <= 1'b0; // [RQ4]
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      monitor_three_quick_trip_o <= 1'b0;
      regulator_pulse_enable_o <= 1'b0;
    end else begin
      monitor_three_quick_trip_o <= qt_internal; // [RQ5]
      // Regulator waits for the trip input to drop too
      regulator_pulse_enable_o <= loaded_reg & ~qt_internal &
                                  ~monitor_three_trip_i; // [RQ4]
    end
  end

  // Password entry; byte at 7Bh is the top byte
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwe_reg <= `MWG_PWE_RESET; // [RQ14]
    end else if (wr_en_i && addr_i >= `MWG_ADDR_PWE_0 &&
                 addr_i <= `MWG_ADDR_PWE_3) begin
      case (pwe_idx)
        2'd0: pwe_reg[31:24] <= wdata_i; // [RQ19]
        2'd1: pwe_reg[23:16] <= wdata_i;
        2'd2: pwe_reg[15:8] <= wdata_i;
        default: pwe_reg[7:0] <= wdata_i; // [RQ19]
      endcase
    end
  end

  // References arrive from the protected store as plain inputs
  mwg_pw_cmp #(.WIDTH(PW_WIDTH)) u_cmp_one (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .entry_i(pwe_reg),
    .ref_i(level_one_password_i), // [RQ16]
    .match_o(m1)
  );
  mwg_pw_cmp #(.WIDTH(PW_WIDTH)) u_cmp_two (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .entry_i(pwe_reg),
    .ref_i(level_two_password_i), // [RQ16]
    .match_o(m2)
  );

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_one_access_o <= 1'b0;
      level_two_access_o <= 1'b0;
    end else begin
      level_one_access_o <= m1 | m2; // [RQ15]
      level_two_access_o <= m2; // [RQ15]
    end
  end

  // Pin drive selection with routing
  always @* begin
    drive_next = dout_reg[3:0]; // [RQ6]
    if (route_reg[`MWG_BIT_QT_SEL-4]) begin
      drive_next[2] = qt_internal ^ route_reg[`MWG_BIT_QT_INV-4]; // [RQ9] [RQ10]
    end
    if (route_reg[`MWG_BIT_LOS_SEL-4]) begin
      drive_next[0] = signal_absent_input_i ^
                      route_reg[`MWG_BIT_LOS_INV-4]; // [RQ11] [RQ12]
    end
    // Pins float until defaults are in, avoiding a glitch low
    if (!loaded_reg) begin
      drive_next = 4'hF;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      mwg_od_pin u_pin (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .level_i(drive_next[gi]),
        .pin_i(gpio_pin_i[gi]),
        .pin_o(gpio_pin_o[gi]),
        .pin_oe_o(gpio_pin_oe_o[gi]),
        .level_o(pin_level[gi])
      );
    end
  endgenerate

  // Read decode; other writes fall through untouched
  always @* begin
    rdata_next = `MWG_ZERO_BYTE; // [RQ3] [RQ18]
    if (addr_i == `MWG_ADDR_WARN) begin
      rdata_next = warn_reg;
    end else if (addr_i == `MWG_ADDR_DOUT_CTL) begin
      rdata_next = dout_reg;
    end else if (addr_i == `MWG_ADDR_PIN_IN) begin
      rdata_next = {route_reg, pin_level}; // [RQ8] [RQ13]
    end else if (addr_i >= `MWG_ADDR_PWE_0 && addr_i <= `MWG_ADDR_PWE_3) begin
      rdata_next = `MWG_ZERO_BYTE; // [RQ14]
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `MWG_ZERO_BYTE;
    end else if (rd_en_i) begin
      rdata_o <= rdata_next;
    end
  end
endmodule // mwg_regs

// [rtl/mwg_defs.vh]
// Register map, field positions and reset values of the warning/pin block
`ifndef MWG_DEFS_VH
`define MWG_DEFS_VH

`define MWG_ADDR_WARN 8'h75
`define MWG_ADDR_RSVD_A 8'h76
`define MWG_ADDR_RSVD_B 8'h77
`define MWG_ADDR_DOUT_CTL 8'h78
`define MWG_ADDR_PIN_IN 8'h79
`define MWG_ADDR_RSVD_C 8'h7A
`define MWG_ADDR_PWE_0 8'h7B
`define MWG_ADDR_PWE_3 8'h7E

`define MWG_BIT_M3_HI 7
`define MWG_BIT_M3_LO 6
`define MWG_BIT_M4_HI 5
`define MWG_BIT_M4_LO 4
`define MWG_BIT_QT_CLR 7
`define MWG_BIT_QT_FORCE 6
`define MWG_BIT_QT_INV 7
`define MWG_BIT_QT_SEL 6
`define MWG_BIT_LOS_INV 5
`define MWG_BIT_LOS_SEL 4

`define MWG_PWE_RESET 32'hFFFF_FFFF
`define MWG_ZERO_BYTE 8'h00

`endif

// [rtl/mwg_od_pin.v]
// One open-drain pin: drive low or release, sample pin level
`timescale 1ns/1ps
module mwg_od_pin (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire level_i,
  input wire pin_i,
  output reg pin_o,
  output reg pin_oe_o,
  output reg level_o
);
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      level_o <= 1'b0;
    end else begin
      pin_o <= 1'b0;
      pin_oe_o <= ~level_i; // [RQ6]
      level_o <= pin_i; // [RQ8]
    end
  end
endmodule // mwg_od_pin

// [rtl/mwg_pw_cmp.v]
// Compares the entered password with one stored reference
`timescale 1ns/1ps
module mwg_pw_cmp #(
  parameter WIDTH = 32
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] entry_i,
  input wire [WIDTH-1:0] ref_i,
  output reg match_o
);
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_o <= 1'b0;
    end else begin
      match_o <= (entry_i == ref_i); // [RQ17]
    end
  end
endmodule // mwg_pw_cmp

// [testbench/mwg_regs_sva.sv]
// Concurrent checks on the warning, pin and password register block
`timescale 1ns/1ps
module mwg_regs_sva (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire monitor_three_trip_i,
  input wire [7:0] powerup_pin_defaults_i,
  input wire defaults_valid_i,
  input wire signal_absent_input_i,
  input wire [3:0] gpio_pin_oe_o,
  input wire monitor_three_quick_trip_o,
  input wire regulator_pulse_enable_o,
  input wire level_one_access_o,
  input wire level_two_access_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  reg recalled;
  wire wr_out;
  wire alarm;
  // Writes to 78h are ignored until the defaults byte has been taken
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      recalled <= 1'b0;
    end else if (defaults_valid_i) begin
      recalled <= 1'b1;
    end
  end
  assign wr_out = recalled && wr_en_i && addr_i == 8'h78;
  assign alarm = monitor_three_quick_trip_o;
  chk_rsvd_zero:
    assert property (rd_en_i && addr_i inside {8'h76, 8'h7A, 8'h7D}
      |=> rdata_o == 8'h00) else $error("reserved read not zero");
  chk_read_hold:
    assert property (!rd_en_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
  chk_pin_drive:
    assert property (wr_out |-> ##2 gpio_pin_oe_o[3] != $past(wdata_i[3], 2)
      && gpio_pin_oe_o[1] != $past(wdata_i[1], 2)) else $error("pin drive");
  chk_force_alarm:
    assert property (wr_out && wdata_i[6] |-> ##[1:3]
      (alarm && !regulator_pulse_enable_o)) else $error("force ignored");
  chk_trip_stop:
    assert property (monitor_three_trip_i |-> ##[1:4]
      (alarm && !regulator_pulse_enable_o)) else $error("trip ignored");
  chk_route_trip:
    assert property ((recalled && powerup_pin_defaults_i[6]
      && $stable(alarm))[*4]
      |-> gpio_pin_oe_o[2] == (alarm == powerup_pin_defaults_i[7]))
      else $error("routed trip pin wrong");
  chk_route_absent:
    assert property ((recalled && powerup_pin_defaults_i[4]
      && $stable(signal_absent_input_i))[*4] |-> gpio_pin_oe_o[0]
      == (signal_absent_input_i == powerup_pin_defaults_i[5]))
      else $error("routed absent pin wrong");
  chk_level_nest:
    assert property (level_two_access_o |-> level_one_access_o)
      else $error("level two without level one");
endmodule // mwg_regs_sva
bind mwg_regs mwg_regs_sva u_mwg_regs_sva (.clk_sys_i, .nrst_i, .wr_en_i,
  .rd_en_i, .addr_i, .wdata_i, .rdata_o, .monitor_three_trip_i,
  .powerup_pin_defaults_i, .defaults_valid_i, .signal_absent_input_i,
  .gpio_pin_oe_o,
  .monitor_three_quick_trip_o, .regulator_pulse_enable_o,
  .level_one_access_o, .level_two_access_o);

// [testbench/mwg_pin_model.sv]
// Board side of the four open-drain pins: pull-ups plus external pull-down
`timescale 1ns/1ps
module mwg_pin_model (
  input wire [3:0] pin_oe_i,
  input wire [3:0] pin_drv_i,
  input wire [3:0] ext_low_i,
  output wire [3:0] level_o
);
  // Released pins rise through the pull-up, never hold the last value
  assign level_o = ~ext_low_i & (~pin_oe_i | pin_drv_i);
endmodule // mwg_pin_model

// [testbench/mwg_regs_bench.sv]
// Self-checking bench for the warning, pin and password registers
`timescale 1ns/1ps
module mwg_regs_bench;
  localparam [7:0] PD = 8'hDA;
  // Second defaults byte: inversions set, both routes off
  localparam [7:0] PD2 = 8'hA3;
  localparam [31:0] PW1 = 32'h1234_5678;
  localparam [31:0] PW2 = 32'h9ABC_DEF0;
  reg clk_sys_i = 0, nrst_i = 0, wr_en_i = 0, rd_en_i = 0;
  reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  reg monitor_three_high_warning_i = 0, monitor_three_low_warning_i = 0;
  reg monitor_four_high_warning_i = 0, monitor_four_low_warning_i = 0;
  reg monitor_three_trip_i = 0, signal_absent_input_i = 0;
  reg defaults_valid_i = 1;
  reg [7:0] powerup_pin_defaults_i = PD;
  reg [31:0] level_one_password_i = PW1, level_two_password_i = PW2;
  reg [3:0] ext_low = 4'h0;
  wire [7:0] rdata_o;
  wire [3:0] gpio_pin_i, gpio_pin_o, gpio_pin_oe_o;
  wire monitor_three_quick_trip_o, regulator_pulse_enable_o;
  wire level_one_access_o, level_two_access_o;
  integer miscompares = 0, check_count = 0, i;
  mwg_regs u_mwg_regs (.clk_sys_i, .nrst_i, .wr_en_i, .rd_en_i, .addr_i,
    .wdata_i, .rdata_o, .monitor_three_high_warning_i,
    .monitor_three_low_warning_i, .monitor_four_high_warning_i,
    .monitor_four_low_warning_i, .monitor_three_trip_i,
    .powerup_pin_defaults_i, .defaults_valid_i, .level_one_password_i,
    .level_two_password_i, .signal_absent_input_i, .gpio_pin_i,
    .gpio_pin_o, .gpio_pin_oe_o, .monitor_three_quick_trip_o,
    .regulator_pulse_enable_o, .level_one_access_o, .level_two_access_o);
  mwg_pin_model u_mwg_pin_model (.pin_oe_i(gpio_pin_oe_o),
    .pin_drv_i(gpio_pin_o), .ext_low_i(ext_low), .level_o(gpio_pin_i));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys_i);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_en_i <= 1'b0;
      #1 chk($sformatf("addr %h", a), rdata_o, e);
    end
  endtask
  // Covers the three-edge password path, the longest in the block
  task settle;
    begin
      repeat (4) @(posedge clk_sys_i);
      #1;
    end
  endtask
  task flags(input [7:0] e);
    chk("alarm", {6'h0, monitor_three_quick_trip_o,
      regulator_pulse_enable_o}, e);
  endtask
  task access(input [7:0] e);
    chk("access", {6'h0, level_two_access_o, level_one_access_o}, e);
  endtask
  task pw(input [31:0] v);
    begin
      for (i = 0; i < 4; i = i + 1)
        wr(8'h7B + i[7:0], v[31-8*i -: 8]);
      settle;
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    settle;
    rd(8'h78, PD & 8'h4F);
    for (i = 0; i < 2; i = i + 1) begin
      {monitor_three_high_warning_i, monitor_three_low_warning_i,
        monitor_four_high_warning_i, monitor_four_low_warning_i} <=
        i ? 4'b0110 : 4'b1001;
      rd(8'h75, i ? 8'h60 : 8'h90);
    end
    for (i = 8'h75; i < 8'h80; i = i + 1) if (i != 8'h78) wr(i[7:0], 8'hFF);
    rd(8'h75, 8'h60);
    for (i = 8'h76; i < 8'h80; i = i + 1)
      if (i != 8'h78 && i != 8'h79) rd(i[7:0], 8'h00);
    wr(8'h78, 8'h35);
    rd(8'h78, 8'h05);
    settle;
    chk("oe", {4'h0, gpio_pin_oe_o}, 8'h0B);
    chk("drive", {4'h0, gpio_pin_o}, 8'h00);
    rd(8'h79, {PD[7:4], 4'b0100});
    ext_low <= 4'b0100;
    settle;
    rd(8'h79, {PD[7:4], 4'b0000});
    ext_low <= 4'b0000;
    signal_absent_input_i <= 1'b1;
    settle;
    rd(8'h79, {PD[7:4], 4'b0101});
    wr(8'h78, 8'h45);
    settle;
    flags(8'h02);
    rd(8'h79, {PD[7:4], 4'b0001});
    wr(8'h78, 8'h05);
    monitor_three_trip_i <= 1'b1;
    settle;
    wr(8'h78, 8'h85);
    settle;
    flags(8'h02);
    monitor_three_trip_i <= 1'b0;
    settle;
    flags(8'h02);
    wr(8'h78, 8'h85);
    settle;
    flags(8'h01);
    rd(8'h78, 8'h05);
    access(8'h00);
    pw(PW1);
    access(8'h01);
    pw(PW2);
    access(8'h03);
    wr(8'h7E, 8'h00);
    settle;
    access(8'h00);
    // Second reset: defaults byte arrives late, routes off
    nrst_i <= 1'b0;
    defaults_valid_i <= 1'b0;
    powerup_pin_defaults_i <= PD2;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    wr(8'h78, 8'h0F);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h0F);
    chk("oe", {4'h0, gpio_pin_oe_o}, 8'h00);
    flags(8'h00);
    access(8'h00);
    defaults_valid_i <= 1'b1;
    settle;
    rd(8'h78, PD2 & 8'h4F);
    flags(8'h01);
    chk("oe", {4'h0, gpio_pin_oe_o}, 8'h0C);
    rd(8'h79, {PD2[7:4], 4'b0011});
    pw(PW1);
    access(8'h01);
    stop_test;
  end
  initial begin
    #80000;
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule // mwg_regs_bench
